// ===== touch_mode_defines.vh
// Constants for the host mode register group of the touch controller
// Assumes inclusion by bare name from files in the same folder
`ifndef TOUCH_MODE_DEFINES_VH
`define TOUCH_MODE_DEFINES_VH

// ==========================================================
// Register offsets
`define OFS_MODE_CTRL      8'h00
`define OFS_OUT_LEVELS     8'h01
`define OFS_CFG_STATUS     8'h03

// ==========================================================
// Reset values
`define RST_MODE_CTRL      8'h00
`define RST_OUT_LEVELS     8'h00
`define RST_BYTE           8'h00
`define RST_MODE_FIELD     3'h0
`define RST_OUT_FIELD      4'h0
`define RST_FACTORY        1'h0
`define RST_BIT            1'h0

// ==========================================================
// Field positions
`define BIT_DEEP_SLEEP     4
`define BIT_SOFT_RESET     3
`define MODE_HI            2
`define MODE_LO            0
`define OUT_HI             7
`define OUT_LO             4
`define BIT_FACTORY        6

// ==========================================================
// Mode codes
`define MODE_NORMAL        3'h0
`define MODE_LED_CFG       3'h1
`define MODE_DEV_CFG       3'h2
`define MODE_LINE_TEST     3'h3
`define MODE_DEBUG         3'h4

`endif

// ===== self_clearing_write.v
// One self clearing write bit: set by a host write of 1, cleared when done
// Assumes done is a one-cycle pulse from the logic that serves the action
`timescale 1ns/1ps
module self_clearing_write (
  input  wire clk,
  input  wire rst,
  input  wire set_req,
  input  wire done,
  output wire pending
);
  reg bit_q;
  reg bit_d;

  // ==========================================================
  // Set wins over clear
  always @* begin
    bit_d = bit_q;
    if (done)
      bit_d = 1'b0;
    if (set_req)
      bit_d = 1'b1;
  end

  always @(posedge clk) begin
    if (rst)
      bit_q <= 1'b0;
    else
      bit_q <= bit_d;
  end

  assign pending = bit_q;
endmodule

// ===== mode_code_check.v
// Decode of the device mode field
// Assumes a three bit code written by the host
`timescale 1ns/1ps
`include "touch_mode_defines.vh"
module mode_code_check (
  input  wire [2:0] code,
  output reg        valid
);
  // ==========================================================
  // Valid codes are 000 to 100
  always @* begin
    case (code)
      `MODE_NORMAL,
      `MODE_LED_CFG,
      `MODE_DEV_CFG,
      `MODE_LINE_TEST,
      `MODE_DEBUG: valid = 1'b1;
      default:     valid = 1'b0;
    endcase
  end
endmodule

// ===== touch_ctrl_host_mode_regs.v
// Host mode register group of a touch button controller
// Assumes a byte register port decoded from the serial host link
// Notes on behaviour
// - Every register comes up at its listed value, read/write ones at zero.
// - Reserved addresses hold nothing defined; this block reads them as zero.
// - Reserved bit positions have no function and writes to them do nothing.
// - Writing 1 to mode bit 4 asks for deep sleep, cleared by the device on exit.
// - Writing 1 to mode bit 3 resets the whole controller, writing 0 does nothing; this block only raises soft_reset_req and its registers keep their values.
// - Self clearing bits clear once their action is done and then read zero.
// - Mode bits 2:0 pick normal, LED config, device config, line test or debug.
// - Output register bits 7:4 drive the four host outputs 3:0 directly.
// - Status bit 6 is read only and shows that factory defaults were loaded.
`timescale 1ns/1ps
`include "touch_mode_defines.vh"
module touch_ctrl_host_mode_regs (
  input  wire       clk,
  input  wire       rst,
  input  wire       reg_wr,
  input  wire       reg_rd,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata,
  input  wire       factory_loaded,
  input  wire       cfg_load_done,
  input  wire       deep_sleep_exit,
  input  wire       soft_reset_done,
  output wire       deep_sleep_req,
  output wire       soft_reset_req,
  output wire [2:0] device_mode,
  output wire [3:0] general_output_pin
);
  // ==========================================================
  // Register state
  reg  [2:0] mode_q;
  reg  [2:0] mode_d;
  reg  [3:0] out_q;
  reg  [3:0] out_d;
  reg        factory_q;
  reg        factory_d;
  reg  [7:0] rdata_d;

  // ==========================================================
  // Decode results
  wire       mode_valid;
  wire       sel_mode;
  wire       sel_out;
  wire       sel_stat;
  wire       wr_mode;
  wire       wr_out;
  wire       sleep_set;
  wire       sreset_set;
  wire [2:0] wr_code;
  wire [3:0] wr_levels;
  wire [7:0] mode_word;
  wire [7:0] out_word;
  wire [7:0] stat_word;

  // ==========================================================
  // Address decode
  assign sel_mode = (reg_addr == `OFS_MODE_CTRL);
  assign sel_out  = (reg_addr == `OFS_OUT_LEVELS);
  assign sel_stat = (reg_addr == `OFS_CFG_STATUS);

  // ==========================================================
  // Write strobes
  // Status register is read only, so it has no strobe
  assign wr_mode = reg_wr && sel_mode;
  assign wr_out  = reg_wr && sel_out;

  // ==========================================================
  // Write fields
  assign wr_code    = reg_wdata[`MODE_HI:`MODE_LO];
  assign wr_levels  = reg_wdata[`OUT_HI:`OUT_LO];
  assign sleep_set  = wr_mode && reg_wdata[`BIT_DEEP_SLEEP];
  assign sreset_set = wr_mode && reg_wdata[`BIT_SOFT_RESET];

  // ==========================================================
  // Mode code decode
  mode_code_check u_check (
    .code  (wr_code),
    .valid (mode_valid)
  );

  // ==========================================================
  // Deep sleep request
  // Cleared by the sleep logic once the device has woken up
  self_clearing_write u_sleep (
    .clk     (clk),
    .rst     (rst),
    .set_req (sleep_set),
    .done    (deep_sleep_exit),
    .pending (deep_sleep_req)
  );

  // ==========================================================
  // Soft reset request
  // Outside logic resets the controller and then reports done
  self_clearing_write u_sreset (
    .clk     (clk),
    .rst     (rst),
    .set_req (sreset_set),
    .done    (soft_reset_done),
    .pending (soft_reset_req)
  );

  // ==========================================================
  // Mode field next value
  // An invalid code leaves the running mode in place
  always @* begin
    mode_d = mode_q;
    if (wr_mode && mode_valid) begin
      mode_d = wr_code;
    end
  end

  // ==========================================================
  // Mode field storage
  always @(posedge clk) begin
    if (rst) begin
      mode_q <= `RST_MODE_FIELD;
    end else begin
      mode_q <= mode_d;
    end
  end

  // ==========================================================
  // Output levels next value
  always @* begin
    out_d = out_q;
    if (wr_out) begin
      out_d = wr_levels;
    end
  end

  // ==========================================================
  // Output levels storage
  always @(posedge clk) begin
    if (rst) begin
      out_q <= `RST_OUT_FIELD;
    end else begin
      out_q <= out_d;
    end
  end

  // ==========================================================
  // Configuration source flag next value
  // Captured when the configuration load reports done
  always @* begin
    factory_d = factory_q;
    if (cfg_load_done) begin
      factory_d = factory_loaded;
    end
  end

  // ==========================================================
  // Configuration source flag storage
  always @(posedge clk) begin
    if (rst) begin
      factory_q <= `RST_FACTORY;
    end else begin
      factory_q <= factory_d;
    end
  end

  // ==========================================================
  // Read word of the mode register
  // Reserved positions read zero
  genvar b;
  generate
    for (b = 0; b < 8; b = b + 1) begin : g_mode_bit
      if (b == `BIT_DEEP_SLEEP) begin : g_sleep
        assign mode_word[b] = deep_sleep_req;
      end else if (b == `BIT_SOFT_RESET) begin : g_sreset
        assign mode_word[b] = soft_reset_req;
      end else if (b <= `MODE_HI) begin : g_code
        assign mode_word[b] = mode_q[b - `MODE_LO];
      end else begin : g_rsvd
        assign mode_word[b] = `RST_BIT;
      end
    end
  endgenerate

  // ==========================================================
  // Read word of the output levels register
  generate
    for (b = 0; b < 8; b = b + 1) begin : g_out_bit
      if (b >= `OUT_LO) begin : g_level
        assign out_word[b] = out_q[b - `OUT_LO];
      end else begin : g_rsvd
        assign out_word[b] = `RST_BIT;
      end
    end
  endgenerate

  // ==========================================================
  // Read word of the status register
  generate
    for (b = 0; b < 8; b = b + 1) begin : g_stat_bit
      if (b == `BIT_FACTORY) begin : g_factory
        assign stat_word[b] = factory_q;
      end else begin : g_rsvd
        assign stat_word[b] = `RST_BIT;
      end
    end
  endgenerate

  // ==========================================================
  // Read select
  always @* begin
    rdata_d = `RST_BYTE;
    case (1'b1)
      sel_mode: begin
        rdata_d = mode_word;
      end
      sel_out: begin
        rdata_d = out_word;
      end
      sel_stat: begin
        rdata_d = stat_word;
      end
      default: begin
        rdata_d = `RST_BYTE;
      end
    endcase
  end

  // ==========================================================
  // Read data register
  // Holds the last read until the next read strobe
  always @(posedge clk) begin
    if (rst) begin
      reg_rdata <= `RST_BYTE;
    end else if (reg_rd) begin
      reg_rdata <= rdata_d;
    end
  end

  // ==========================================================
  // Mode output
  assign device_mode = mode_q;

  // ==========================================================
  // Host driven pins, one per level bit
  generate
    for (b = 0; b < 4; b = b + 1) begin : g_pin
      assign general_output_pin[b] = out_q[b];
    end
  endgenerate
endmodule

// ===== action_agent.sv
// Model of the logic that serves deep sleep and soft reset requests
// Assumes the clock and reset of the register group
`timescale 1ns/1ps
module action_agent (
  input  wire clk,
  input  wire rst,
  input  wire req_a,
  input  wire req_b,
  output reg  done_a,
  output reg  done_b
);
  reg [2:0] ca_q;
  reg [2:0] cb_q;
  // ====
  // Pulse done a few cycles after a request
  always @(posedge clk) begin
    ca_q   <= (req_a && !done_a && !rst) ? ca_q + 3'h1 : 3'h0;
    cb_q   <= (req_b && !done_b && !rst) ? cb_q + 3'h1 : 3'h0;
    done_a <= req_a && ca_q == 3'h3 && !rst;
    done_b <= req_b && cb_q == 3'h3 && !rst;
  end
endmodule

// ===== touch_sva.sv
// Checker for the host mode register group
// Assumes a bind to the top module ports
`timescale 1ns/1ps
module touch_sva (
  input wire       clk,
  input wire       rst,
  input wire       reg_wr,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       deep_sleep_exit,
  input wire       soft_reset_done,
  input wire       deep_sleep_req,
  input wire       soft_reset_req,
  input wire [2:0] device_mode,
  input wire [3:0] general_output_pin
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire w0 = reg_wr && reg_addr == 8'h00;
  // ====
  // Properties
  a_out_levels: assert property (reg_wr && reg_addr == 8'h01 |=>
    general_output_pin == $past(reg_wdata[7:4])) else $error("pins");
  a_mode_ok: assert property (w0 && reg_wdata[2:0] < 3'h5 |=>
    device_mode == $past(reg_wdata[2:0])) else $error("mode");
  a_mode_bad: assert property (w0 && reg_wdata[2:0] > 3'h4 |=> $stable(device_mode))
    else $error("bad mode");
  a_sleep_set: assert property (w0 && reg_wdata[4] |=> deep_sleep_req) else $error("sleep");
  a_sleep_clr: assert property (deep_sleep_exit && !(w0 && reg_wdata[4]) |=>
    !deep_sleep_req) else $error("sleep clr");
  a_reset_set: assert property (w0 && reg_wdata[3] |=> soft_reset_req) else $error("srst");
  a_reset_clr: assert property (soft_reset_done && !(w0 && reg_wdata[3]) |=>
    !soft_reset_req) else $error("srst clr");
  a_reset_zero: assert property (w0 && !reg_wdata[3] && !soft_reset_req |=>
    !soft_reset_req) else $error("srst zero");
  cover property (w0 && reg_wdata[4]);
  cover property (soft_reset_done);
  cover property (w0 && reg_wdata[2:0] == 3'h7);
endmodule

// ===== tb.sv
// Self-checking bench for the host mode register group
// Assumes the design, checker and agent files
`timescale 1ns/1ps
module tb;
  reg        clk = 1'h0, rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0;
  reg        factory_loaded = 1'h0, cfg_load_done = 1'h0;
  reg  [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
  wire [7:0] reg_rdata;
  wire       deep_sleep_exit, soft_reset_done, deep_sleep_req, soft_reset_req;
  wire [2:0] device_mode;
  wire [3:0] general_output_pin;
  int        error_cnt = 0, checks_done = 0, mode = 0, i, d;
  int        m_mode = 0, m_out = 0, m_fac = 0;
  byte       exp_q[$];
  function automatic [7:0] model_rd(input [7:0] a);
    if (a == 8'h00) model_rd = m_mode[7:0];
    else if (a == 8'h01) model_rd = {m_out[3:0], 4'h0};
    else if (a == 8'h03) model_rd = {1'h0, m_fac[0], 6'h00};
    else model_rd = 8'h00;
  endfunction
  initial forever #10 clk = ~clk;
  touch_ctrl_host_mode_regs DUT (.*);
  action_agent agent (.clk(clk), .rst(rst), .req_a(deep_sleep_req), .req_b(soft_reset_req),
    .done_a(deep_sleep_exit), .done_b(soft_reset_done));
  // ====
  // Tasks
  task chk(input [7:0] got, input [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input [7:0] a, input [7:0] v);
    @(negedge clk) {reg_wr, reg_addr, reg_wdata} = {1'h1, a, v};
    if (a == 8'h00 && v[2:0] < 3'h5) m_mode = v[2:0];
    if (a == 8'h01) m_out = v[7:4];
    @(negedge clk) reg_wr = 1'h0;
  endtask
  task rd(input [7:0] a, input [7:0] e);
    @(negedge clk) {reg_rd, reg_addr} = {1'h1, a};
    exp_q.push_back(model_rd(a));
    @(negedge clk) reg_rd = 1'h0;
    chk(reg_rdata, e);
    chk(reg_rdata, exp_q.pop_front());
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #200000;
    error_cnt++;
    wrap_up;
  end
  // ====
  // Tests
  initial begin
    d = $urandom(21);
    repeat (8) @(negedge clk);
    rst = 1'h0;
    for (i = 0; i < 4; i++) rd(i[7:0], 8'h00);
    $display("reset test end");
    for (i = 0; i < 6; i++) begin
      d = $urandom;
      wr(8'h01, d[7:0]);
      chk({4'h0, general_output_pin}, {4'h0, d[7:4]});
      rd(8'h01, {d[7:4], 4'h0});
    end
    $display("output test end");
    for (i = 0; i < 8; i++) begin
      wr(8'h00, {5'h1c, i[2:0]});
      if (i < 5) mode = i;
      chk({5'h0, device_mode}, mode[7:0]);
      rd(8'h00, mode[7:0]);
    end
    $display("mode test end");
    for (i = 3; i < 5; i++) begin
      wr(8'h00, 8'h04 | (8'h01 << i));
      chk({6'h0, deep_sleep_req, soft_reset_req}, {6'h0, i == 4, i == 3});
      for (d = 0; d < 20 && (deep_sleep_req || soft_reset_req); d++) @(negedge clk);
      rd(8'h00, 8'h04);
    end
    $display("clear test end");
    @(negedge clk);
    factory_loaded = 1'h1;
    cfg_load_done = 1'h1;
    m_fac = 1;
    @(negedge clk);
    cfg_load_done = 1'h0;
    wr(8'h03, 8'hff);
    rd(8'h03, 8'h40);
    d = $urandom_range(255, 4);
    rd(d[7:0], 8'h00);
    $display("status test end");
    wrap_up;
  end
endmodule
bind touch_ctrl_host_mode_regs touch_sva chk_i (.*);
